// [inc/sctim_pkg.sv]
// sctim_pkg: opcode encodings, instruction classes, lengths and cycle counts
// assumes: one core clock, one opcode byte offered per fetch handshake
`default_nettype none
package sctim_pkg;
    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int OP_W = 8;
    localparam int LEN_W = 2;
    localparam int CYC_W = 4;
    localparam int WAIT_W = 3;
    localparam int RN_BIT = 3; // set in the low nibble of bank register forms
    // ****************************************************************
    // lengths and cycle counts
    // ****************************************************************
    localparam logic [LEN_W-1:0] LEN_ONE = 2'h1;
    localparam logic [LEN_W-1:0] LEN_TWO = 2'h2;
    localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;
    localparam logic [CYC_W-1:0] CYC_ONE = 4'h1;
    localparam logic [CYC_W-1:0] CYC_TWO = 4'h2;
    localparam logic [CYC_W-1:0] CYC_THREE = 4'h3;
    localparam logic [CYC_W-1:0] CYC_FOUR = 4'h4;
    localparam logic [CYC_W-1:0] CNT_LAST = 4'h1; // counter value in the final cycle
    // ****************************************************************
    // opcode encodings
    // ****************************************************************
    localparam logic [3:0] HI_ADD = 4'h2;
    localparam logic [3:0] HI_ADDC = 4'h3;
    localparam logic [3:0] HI_SUBB = 4'h9;
    localparam logic [3:0] HI_ORL = 4'h4;
    localparam logic [3:0] HI_ANL = 4'h5;
    localparam logic [3:0] HI_XRL = 4'h6;
    localparam logic [3:0] HI_XCH = 4'hc;
    localparam logic [3:0] HI_XCHD = 4'hd;
    localparam logic [3:0] HI_MOV_A_IND = 4'he;
    localparam logic [3:0] HI_MOV_IND_A = 4'hf;
    localparam logic [3:0] LO_ABS = 4'h1;
    localparam logic [3:0] LO_DIR_ACC = 4'h2;
    localparam logic [3:0] LO_DIR_IMM = 4'h3;
    localparam logic [3:0] LO_IMM = 4'h4;
    localparam logic [3:0] LO_DIR = 4'h5;
    localparam logic [3:0] LO_IND0 = 4'h6;
    localparam logic [3:0] LO_IND1 = 4'h7;
    localparam logic [3:0] LO_X_DP = 4'h0;
    localparam logic [OP_W-1:0] OP_RR_A = 8'h03, OP_RRC_A = 8'h13, OP_RL_A = 8'h23;
    localparam logic [OP_W-1:0] OP_RLC_A = 8'h33, OP_SWAP_A = 8'hc4, OP_CLR_A = 8'he4;
    localparam logic [OP_W-1:0] OP_CPL_A = 8'hf4, OP_MOV_DD = 8'h85, OP_MOV_DI = 8'h75;
    localparam logic [OP_W-1:0] OP_LOAD_DP = 8'h90, OP_CODE_DP = 8'h93, OP_CODE_PC = 8'h83;
    localparam logic [OP_W-1:0] OP_PUSH = 8'hc0, OP_POP = 8'hd0, OP_JMP_IND = 8'h73;
    localparam logic [OP_W-1:0] OP_MOV_CB = 8'ha2, OP_MOV_BC = 8'h92, OP_ANL_CB = 8'h82;
    localparam logic [OP_W-1:0] OP_ANL_CNB = 8'hb0, OP_ORL_CB = 8'h72, OP_ORL_CNB = 8'ha0;

    // instruction timing classes
    typedef enum logic [4:0] {
        CL_REG_ALU, CL_IND_ALU, CL_DIR_ALU, CL_LOG_DIR_IMM, CL_LOG_DIR_ACC,
        CL_ACC_UNARY, CL_IND_MOV, CL_MOV_THREE, CL_DP_LOAD, CL_CODE_READ,
        CL_XDATA, CL_STACK, CL_XCH_IND, CL_BOOL, CL_JMP_IND, CL_ABS, CL_OTHER
    } sctim_class_e;

    // map an opcode byte to its timing class
    function automatic sctim_class_e sctim_classify(input logic [OP_W-1:0] op);
        logic [3:0] hi;
        logic [3:0] lo;
        logic alu_row;
        logic log_row;
        logic ind;
        sctim_class_e cl;
        hi = op[7:4];
        lo = op[3:0];
        log_row = (hi == HI_ANL) || (hi == HI_ORL) || (hi == HI_XRL);
        alu_row = log_row || (hi == HI_ADD) || (hi == HI_ADDC) || (hi == HI_SUBB);
        ind = (lo == LO_IND0) || (lo == LO_IND1);
        cl = CL_OTHER;
        if (lo == LO_ABS) cl = CL_ABS;
        else if (alu_row && op[RN_BIT]) cl = CL_REG_ALU;
        else if (alu_row && ind) cl = CL_IND_ALU;
        else if (alu_row && (lo == LO_IMM || lo == LO_DIR)) cl = CL_DIR_ALU;
        else if (log_row && lo == LO_DIR_IMM) cl = CL_LOG_DIR_IMM;
        else if (log_row && lo == LO_DIR_ACC) cl = CL_LOG_DIR_ACC;
        else if ((hi == HI_MOV_A_IND || hi == HI_MOV_IND_A) && ind) cl = CL_IND_MOV;
        else if ((hi == HI_MOV_A_IND || hi == HI_MOV_IND_A)
                 && (lo == LO_X_DP || lo == LO_DIR_ACC || lo == LO_DIR_IMM)) cl = CL_XDATA;
        else if ((hi == HI_XCH || hi == HI_XCHD) && ind) cl = CL_XCH_IND;
        else if (op == OP_CLR_A || op == OP_CPL_A || op == OP_SWAP_A || op == OP_RL_A
                 || op == OP_RLC_A || op == OP_RR_A || op == OP_RRC_A) cl = CL_ACC_UNARY;
        else if (op == OP_MOV_DD || op == OP_MOV_DI) cl = CL_MOV_THREE;
        else if (op == OP_LOAD_DP) cl = CL_DP_LOAD;
        else if (op == OP_CODE_DP || op == OP_CODE_PC) cl = CL_CODE_READ;
        else if (op == OP_PUSH || op == OP_POP) cl = CL_STACK;
        else if (op == OP_JMP_IND) cl = CL_JMP_IND;
        else if (op == OP_MOV_CB || op == OP_MOV_BC || op == OP_ANL_CB || op == OP_ANL_CNB
                 || op == OP_ORL_CB || op == OP_ORL_CNB) cl = CL_BOOL;
        return cl;
    endfunction
endpackage
`default_nettype wire

// [hdl/sctim_op_lut.sv]
// sctim_op_lut: opcode to class, byte length and base cycle count
// assumes: purely combinational, caller registers the results
`timescale 1ns/10ps
`default_nettype none
module sctim_op_lut
    import sctim_pkg::*;
(
    input wire logic [sctim_pkg::OP_W-1:0] op,
    output sctim_pkg::sctim_class_e cls,
    output logic [sctim_pkg::LEN_W-1:0] len,
    output logic [sctim_pkg::CYC_W-1:0] cyc,
    output logic known
);
    // class lookup, then table of length and cycles per class
    always_comb begin
        cls = sctim_classify(op);
        known = 1'b1;
        case (cls)
            CL_REG_ALU, CL_ACC_UNARY: begin len = LEN_ONE; cyc = CYC_ONE; end
            CL_IND_ALU, CL_IND_MOV, CL_XCH_IND: begin
                len = LEN_ONE; cyc = CYC_TWO;
            end
            CL_DIR_ALU, CL_LOG_DIR_ACC, CL_STACK, CL_BOOL: begin
                len = LEN_TWO; cyc = CYC_TWO;
            end
            CL_LOG_DIR_IMM, CL_MOV_THREE, CL_DP_LOAD: begin
                len = LEN_THREE; cyc = CYC_THREE;
            end
            CL_CODE_READ, CL_XDATA: begin len = LEN_ONE; cyc = CYC_FOUR; end
            CL_JMP_IND: begin len = LEN_ONE; cyc = CYC_THREE; end
            CL_ABS: begin len = LEN_TWO; cyc = CYC_THREE; end
            // unlisted opcodes: treated as one byte, one cycle and flagged
            default: begin len = LEN_ONE; cyc = CYC_ONE; known = 1'b0; end
        endcase
    end
endmodule // sctim_op_lut
`default_nettype wire

// [hdl/sctim_cycle_cnt.sv]
// sctim_cycle_cnt: down counter of remaining execution cycles
// assumes: load is never asserted with a zero count
`timescale 1ns/10ps
`default_nettype none
module sctim_cycle_cnt
    import sctim_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic [sctim_pkg::CYC_W-1:0] load_val,
    output logic [sctim_pkg::CYC_W-1:0] remain
);
    logic [CYC_W-1:0] remain_reg; // cycles still to run, counting the current one
    // one step per core clock, no prescaler
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            remain_reg <= '0;
        end else if (load) begin
            remain_reg <= load_val - CYC_ONE;
        end else if (remain_reg != '0) begin
            remain_reg <= remain_reg - CYC_ONE;
        end
    end
    assign remain = remain_reg;
endmodule // sctim_cycle_cnt
`default_nettype wire

// [hdl/sctim_decoder.sv]
// sctim_decoder: instruction length and cycle decoder for the core sequencer
// assumes: program memory offers one opcode byte with op_valid, held until
// op_ready; wait-state count comes from a register on the same clock
`timescale 1ns/10ps
`default_nettype none
module sctim_decoder
    import sctim_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic [sctim_pkg::OP_W-1:0] op_byte,
    input wire logic [sctim_pkg::WAIT_W-1:0] external_data_move_wait_states,
    output logic op_ready,
    output logic [sctim_pkg::LEN_W-1:0] instr_len,
    output logic [sctim_pkg::CYC_W-1:0] instr_cycles,
    output logic decode_known,
    output logic pc_step,
    output logic exec_busy
);
    import sctim_pkg::*;

    // ****************************************************************
    // sequencing state
    // ****************************************************************
    typedef enum logic [0:0] {
        ST_FETCH, // ready for the next opcode
        ST_EXEC   // spending the remaining cycles of an instruction
    } sctim_state_e;

    sctim_state_e state_reg; // current phase
    sctim_state_e state_next; // phase for the next edge
    logic accept; // opcode taken this cycle
    sctim_class_e lut_cls; // class of the offered opcode
    logic [LEN_W-1:0] lut_len; // byte length from the table
    logic [CYC_W-1:0] lut_cyc; // base cycle count from the table
    logic lut_known; // opcode recognised
    logic [CYC_W-1:0] cyc_total; // count including wait states
    logic [CYC_W-1:0] remain; // cycles left, counting the current one
    logic [LEN_W-1:0] instr_len_reg; // length of last taken opcode
    logic [CYC_W-1:0] instr_cycles_reg; // cycles of last taken opcode
    logic decode_known_reg; // last opcode was recognised
    logic pc_step_reg; // pulse: advance pc by instr_len

    // ****************************************************************
    // decode
    // ****************************************************************
    // table lookup on the byte presented by the fetch path
    sctim_op_lut u_lut (
        .op(op_byte),
        .cls(lut_cls),
        .len(lut_len),
        .cyc(lut_cyc),
        .known(lut_known)
    );

    // external data moves stretch by the programmed wait states
    always_comb begin
        if (lut_cls == CL_XDATA) begin
            cyc_total = lut_cyc + {1'b0, external_data_move_wait_states};
        end else begin
            cyc_total = lut_cyc;
        end
    end

    // ****************************************************************
    // handshake
    // ****************************************************************
    // ready only between instructions, so the next fetch waits out the count
    assign op_ready = (state_reg == ST_FETCH);
    assign accept = op_valid && op_ready;

    // remaining cycle counter, reloaded on every taken opcode
    sctim_cycle_cnt u_cnt (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(accept),
        .load_val(cyc_total),
        .remain(remain)
    );

    // phase transitions; single-cycle opcodes never leave fetch
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_FETCH: begin
                if (accept && cyc_total != CYC_ONE) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                // last counted clock of the instruction
                if (remain == CNT_LAST) begin
                    state_next = ST_FETCH;
                end
            end
            default: state_next = ST_FETCH;
        endcase
    end

    // phase register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= ST_FETCH;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // results to the sequencer
    // ****************************************************************
    // length and count held until the next opcode is taken
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            instr_len_reg <= LEN_ONE;
            instr_cycles_reg <= CYC_ONE;
            decode_known_reg <= 1'b0;
        end else if (accept) begin
            instr_len_reg <= lut_len;
            instr_cycles_reg <= cyc_total;
            decode_known_reg <= lut_known;
        end
    end

    // pc advance pulse, one per taken opcode
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_step_reg <= 1'b0;
        end else begin
            pc_step_reg <= accept;
        end
    end

    assign instr_len = instr_len_reg;
    assign instr_cycles = instr_cycles_reg;
    assign decode_known = decode_known_reg;
    assign pc_step = pc_step_reg;
    assign exec_busy = (state_reg == ST_EXEC);

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // helper: clocks since the last taken opcode, saturating
    logic [CYC_W-1:0] gap_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gap_reg <= '0;
        end else if (accept) begin
            gap_reg <= CYC_ONE;
        end else if (gap_reg != '1) begin
            gap_reg <= gap_reg + CYC_ONE;
        end
    end

    // helper: opcode fields decoded independently of the table
    logic [3:0] f_hi;
    logic [3:0] f_lo;
    logic f_alu;
    logic f_log;
    assign f_hi = op_byte[7:4];
    assign f_lo = op_byte[3:0];
    assign f_log = (f_hi == HI_ANL) || (f_hi == HI_ORL) || (f_hi == HI_XRL);
    assign f_alu = f_log || (f_hi == HI_ADD) || (f_hi == HI_ADDC) || (f_hi == HI_SUBB);

    property p_reg_alu;
        accept && f_alu && op_byte[RN_BIT] |=> instr_len == LEN_ONE && instr_cycles == CYC_ONE;
    endproperty
    a_reg_alu: assert property (p_reg_alu) else $error("bank register op timing wrong");

    property p_ind_alu;
        accept && f_alu && (f_lo == LO_IND0 || f_lo == LO_IND1)
            |=> instr_len == LEN_ONE && !op_ready ##1 op_ready;
    endproperty
    a_ind_alu: assert property (p_ind_alu) else $error("indirect alu op timing wrong");

    property p_dir_alu;
        accept && f_alu && (f_lo == LO_IMM || f_lo == LO_DIR)
            |=> instr_len == LEN_TWO && instr_cycles == CYC_TWO;
    endproperty
    a_dir_alu: assert property (p_dir_alu) else $error("direct alu op timing wrong");

    property p_log_dir_imm;
        accept && f_log && f_lo == LO_DIR_IMM
            |=> instr_len == LEN_THREE && !op_ready [*2] ##1 op_ready;
    endproperty
    a_log_dir_imm: assert property (p_log_dir_imm) else $error("logic imm to direct wrong");

    property p_log_dir_acc;
        accept && f_log && f_lo == LO_DIR_ACC |=> instr_len == LEN_TWO && instr_cycles == CYC_TWO;
    endproperty
    a_log_dir_acc: assert property (p_log_dir_acc) else $error("logic acc to direct wrong");

    property p_acc_unary;
        accept && (op_byte == OP_CLR_A || op_byte == OP_SWAP_A || op_byte == OP_RRC_A)
            |=> op_ready && instr_len == LEN_ONE && instr_cycles == CYC_ONE;
    endproperty
    a_acc_unary: assert property (p_acc_unary) else $error("accumulator op timing wrong");

    property p_ind_mov;
        accept && (f_hi == HI_MOV_A_IND || f_hi == HI_MOV_IND_A) && f_lo == LO_IND1
            |=> instr_len == LEN_ONE && instr_cycles == CYC_TWO;
    endproperty
    a_ind_mov: assert property (p_ind_mov) else $error("indirect move timing wrong");

    property p_mov_three;
        accept && (op_byte == OP_MOV_DD || op_byte == OP_MOV_DI)
            |=> instr_len == LEN_THREE && instr_cycles == CYC_THREE;
    endproperty
    a_mov_three: assert property (p_mov_three) else $error("three byte move wrong");

    property p_dp_load;
        accept && op_byte == OP_LOAD_DP |=> instr_len == LEN_THREE && exec_busy [*2] ##1 !exec_busy;
    endproperty
    a_dp_load: assert property (p_dp_load) else $error("data pointer load wrong");

    property p_code_read;
        accept && (op_byte == OP_CODE_DP || op_byte == OP_CODE_PC)
            |=> instr_len == LEN_ONE && !op_ready [*3] ##1 op_ready;
    endproperty
    a_code_read: assert property (p_code_read) else $error("code byte read timing wrong");

    property p_xdata_nowait;
        accept && (f_hi == HI_MOV_A_IND || f_hi == HI_MOV_IND_A) && f_lo == LO_X_DP
            && external_data_move_wait_states == '0 |=> instr_cycles == CYC_FOUR && !op_ready [*3] ##1 op_ready;
    endproperty
    a_xdata_nowait: assert property (p_xdata_nowait) else $error("external move wrong");

    property p_stack;
        accept && (op_byte == OP_PUSH || op_byte == OP_POP)
            |=> instr_len == LEN_TWO && instr_cycles == CYC_TWO;
    endproperty
    a_stack: assert property (p_stack) else $error("push or pop timing wrong");

    property p_xch;
        accept && (f_hi == HI_XCH || f_hi == HI_XCHD) && f_lo == LO_IND0
            |=> instr_len == LEN_ONE && instr_cycles == CYC_TWO;
    endproperty
    a_xch: assert property (p_xch) else $error("indirect exchange timing wrong");

    property p_bool;
        accept && (op_byte == OP_ANL_CNB || op_byte == OP_MOV_BC || op_byte == OP_ORL_CB)
            |=> instr_len == LEN_TWO && instr_cycles == CYC_TWO;
    endproperty
    a_bool: assert property (p_bool) else $error("boolean carry op timing wrong");

    property p_jmp_ind;
        accept && op_byte == OP_JMP_IND |=> instr_len == LEN_ONE && instr_cycles == CYC_THREE;
    endproperty
    a_jmp_ind: assert property (p_jmp_ind) else $error("indirect jump timing wrong");

    property p_abs;
        accept && f_lo == LO_ABS |=> instr_len == LEN_TWO && !op_ready [*2] ##1 op_ready;
    endproperty
    a_abs: assert property (p_abs) else $error("absolute jump or call wrong");

    // ready returns exactly the counted number of clocks after the take
    property p_one_clock;
        $rose(op_ready) |-> gap_reg == instr_cycles;
    endproperty
    a_one_clock: assert property (p_one_clock) else $error("cycle not one clock");

    property p_wait;
        accept && (f_hi == HI_MOV_A_IND || f_hi == HI_MOV_IND_A)
            && (f_lo == LO_DIR_ACC || f_lo == LO_X_DP)
            |=> instr_cycles == CYC_FOUR + {1'b0, $past(external_data_move_wait_states)};
    endproperty
    a_wait: assert property (p_wait) else $error("wait states not added");

    // one pc step per taken opcode, none otherwise
    property p_step;
        accept |=> pc_step && instr_len == $past(lut_len);
    endproperty
    a_step: assert property (p_step) else $error("pc step missing");

    property p_no_step;
        !accept |=> !pc_step;
    endproperty
    a_no_step: assert property (p_no_step) else $error("spurious pc step");

    // main scenarios
    c_back_to_back: cover property (accept ##1 accept ##1 accept);
    c_code_read: cover property (accept && op_byte == OP_CODE_DP ##4 accept);
    c_xdata_wait: cover property (accept && f_lo == LO_X_DP && f_hi == HI_MOV_A_IND
        && external_data_move_wait_states == 3'h7);
    c_unknown: cover property (accept && !lut_known);
endmodule // sctim_decoder
`default_nettype wire

// [bench/sctim_prog_mem.sv]
// sctim_prog_mem: program memory model offering one opcode byte per fetch
// assumes: the decoder takes a byte at a rising edge with op_valid and op_ready
`timescale 1ns/10ps
`default_nettype none
module sctim_prog_mem (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run,
    input wire logic stall,
    input wire logic op_ready,
    output logic op_valid,
    output logic [7:0] op_byte
);
    logic [7:0] mem [0:255]; // opcode store, filled by the bench
    logic [7:0] pc_reg; // address of the next opcode to offer
    logic took_reg; // the offered byte went in at the last edge
    // step the fetch address on each take
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_reg <= 8'h00;
            took_reg <= 1'b0;
        end else begin
            took_reg <= op_valid && op_ready;
            if (op_valid && op_ready) begin
                pc_reg <= pc_reg + 8'h01;
            end
        end
    end
    // offer after the falling edge; an untaken byte is held as it is
    always @(negedge clk_sys or posedge rst) begin
        if (rst) begin
            op_valid <= 1'b0;
            op_byte <= 8'h5a;
        end else if (!op_valid || took_reg) begin
            op_valid <= run && !stall;
            // idle byte flips every cycle so a stale value is never trusted
            op_byte <= (run && !stall) ? mem[pc_reg] : ~op_byte;
        end
    end
endmodule // sctim_prog_mem
`default_nettype wire

// [bench/sctim_decoder_bench.sv]
// sctim_decoder_bench: random and corner opcode streams through the decoder
// assumes: sctim_pkg compiled first; program memory model drives the fetch side
`timescale 1ns/10ps
`default_nettype none
module sctim_decoder_bench;
    import sctim_pkg::*;
    logic clk_sys = 1'b0;
    logic rst;
    logic run = 1'b0;
    logic stall = 1'b0;
    logic stall_on = 1'b1; // random fetch stalls wanted
    logic fix_en = 1'b0; // wait states pinned instead of random
    logic [2:0] fix_val = 3'h0;
    logic [2:0] external_data_move_wait_states = 3'h0;
    logic op_valid, op_ready, pc_step, exec_busy, decode_known;
    logic [7:0] op_byte;
    logic [1:0] instr_len;
    logic [3:0] instr_cycles;
    logic take_d = 1'b0; // a byte was taken at the last rising edge
    logic [6:0] exp_d = 7'h00; // expected known, length and count
    logic [31:0] rnd;
    int fail_count = 0;
    int check_count = 0;
    int takes = 0;
    int left = 0; // cycles op_ready must still stay low
    integer seed = 32'he0a7;
    always #10 clk_sys = ~clk_sys;
    sctim_decoder sctim_decoder_inst (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid),
        .op_byte(op_byte), .external_data_move_wait_states(external_data_move_wait_states), .op_ready(op_ready),
        .instr_len(instr_len), .instr_cycles(instr_cycles), .decode_known(decode_known),
        .pc_step(pc_step), .exec_busy(exec_busy));
    sctim_prog_mem sctim_prog_mem_inst (.clk_sys(clk_sys), .rst(rst), .run(run),
        .stall(stall), .op_ready(op_ready), .op_valid(op_valid), .op_byte(op_byte));
    // ****************************************************************
    // expectation and checking
    // ****************************************************************
    // {known, length, cycles} worked out per opcode
    function automatic logic [6:0] expect_fn(input logic [7:0] op, input logic [2:0] w);
        logic [3:0] hi;
        logic [3:0] lo;
        logic lg;
        logic alu;
        logic ind;
        hi = op[7:4];
        lo = op[3:0];
        lg = hi inside {4'h4, 4'h5, 4'h6};
        alu = lg || (hi inside {4'h2, 4'h3, 4'h9});
        ind = lo inside {4'h6, 4'h7};
        if (lo == 4'h1) return 7'h63;
        if (alu && op[3]) return 7'h51;
        if (alu && ind) return 7'h52;
        if (alu && lo inside {4'h4, 4'h5}) return 7'h62;
        if (lg && lo == 4'h3) return 7'h73;
        if (lg && lo == 4'h2) return 7'h62;
        if (hi inside {4'he, 4'hf} && ind) return 7'h52;
        if (hi inside {4'he, 4'hf} && lo inside {4'h0, 4'h2, 4'h3}) return 7'h54 + w;
        if (hi inside {4'hc, 4'hd} && ind) return 7'h52;
        case (op)
            8'h03, 8'h13, 8'h23, 8'h33, 8'hc4, 8'he4, 8'hf4: return 7'h51;
            8'h85, 8'h75, 8'h90: return 7'h73;
            8'h93, 8'h83: return 7'h54;
            8'hc0, 8'hd0, 8'ha2, 8'h92, 8'h82, 8'hb0, 8'h72, 8'ha0: return 7'h62;
            8'h73: return 7'h53;
            default: return 7'h11; // unlisted: one byte, one cycle, unknown
        endcase
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        check_count++;
        if (got !== want) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    // note each take; inputs are steady here since they move at the falling edge
    always @(posedge clk_sys) begin
        take_d <= op_valid && op_ready && !rst;
        exp_d <= expect_fn(op_byte, external_data_move_wait_states);
    end
    // outputs are settled half a cycle after the edge
    always @(negedge clk_sys) begin
        if (rst) begin
            left = 0;
            check({pc_step, op_ready, exec_busy, decode_known, instr_cycles}, 8'h41);
            check({6'h0, instr_len}, 8'h01);
        end else begin
            check({7'h0, pc_step}, {7'h0, take_d});
            if (take_d) begin
                takes++;
                check({1'b0, decode_known, instr_len, instr_cycles}, {1'b0, exp_d});
                left = int'(exp_d[3:0]) - 1;
            end
            check({6'h0, op_ready, exec_busy}, {6'h0, left == 0, left != 0});
            if (left > 0) left--;
        end
    end
    // random stalls and wait states, driven at the falling edge
    always @(negedge clk_sys) begin
        rnd = $random(seed);
        stall <= stall_on && (rnd[1:0] == 2'h0);
        external_data_move_wait_states <= fix_en ? fix_val : rnd[4:2];
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic run_pass(input int n, input string name);
        int start;
        start = takes;
        run <= 1'b1;
        for (int k = 0; k < 5000 && takes - start < n; k++) @(negedge clk_sys);
        run <= 1'b0;
        if (takes - start < n) begin
            fail_count++;
            $display("ERROR at %0t: takes got %h expected %h", $time, takes - start, n);
        end
        repeat (16) @(negedge clk_sys);
        $display("test %s done, takes %0d", name, takes - start);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        for (int i = 0; i < 256; i++) sctim_prog_mem_inst.mem[i] = i[7:0];
        repeat (3) @(negedge clk_sys);
        rst <= 1'b0;
        run_pass(256, "every opcode with stalls");
        stall_on = 1'b0;
        for (int i = 0; i < 256; i++) sctim_prog_mem_inst.mem[i] = 8'($random(seed));
        run_pass(256, "random opcodes back to back");
        // external moves between one-cycle ops, at both ends of the wait range
        for (int i = 0; i < 256; i++)
            sctim_prog_mem_inst.mem[i] = i[0] ? 8'h28 : (i[1] ? 8'hf3 : 8'he0);
        fix_en = 1'b1;
        fix_val = 3'h7;
        run_pass(16, "external moves at full wait");
        fix_val = 3'h0;
        run_pass(16, "external moves at no wait");
        fix_en = 1'b0;
        run <= 1'b1;
        repeat (37) @(negedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(negedge clk_sys);
        rst <= 1'b0;
        run_pass(32, "reset in mid run");
        print_verdict();
    end
    // watchdog at 20000 cycles, well beyond the expected run of under two thousand cycles
    initial begin
        #400000;
        fail_count++;
        $display("ERROR at %0t: run did not finish", $time);
        print_verdict();
    end
endmodule // sctim_decoder_bench
`default_nettype wire
